// >>> mrx_pkg.sv
package mrx_pkg;
	localparam int unsigned INSTR_W = 14;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FADDR_W = 7;
	localparam int unsigned PC_W = 13;
	// opcode patterns of the 14-bit instruction word
	localparam logic [13:0] OP_IDLE = 14'h0000;
	localparam logic [13:0] OP_RETURN = 14'h0008;
	localparam logic [13:0] OP_RET_IRQ = 14'h0009;
	localparam logic [6:0] OP_COPY_HI = 7'h01;
	localparam logic [3:0] OP_LOAD_LIT_HI = 4'hC;
	localparam logic [3:0] OP_RET_LIT_HI = 4'hD;
	localparam logic [1:0] OP_LOAD_LIT_DC = 2'h0;
	// field positions and widths inside the instruction word
	localparam int unsigned LIT_LSB = 0;
	localparam int unsigned FADDR_LSB = 0;
	localparam int unsigned DC_LSB = 8;
	localparam int unsigned DC_W = 2;
	localparam int unsigned CLASS_LSB = 10;
	localparam int unsigned CLASS_W = 4;
	localparam int unsigned COPY_LSB = 7;
	localparam int unsigned COPY_W = 7;
	// bit of irq_control_reg that the interrupt return sets
	localparam int unsigned IRQ_EN_BIT = 7;
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [12:0] PC_STEP = 13'h0001;
	localparam logic [7:0] W_RESET = 8'h00;
	typedef enum logic [1:0] {
		MRX_EXEC = 2'h0,
		MRX_IDLE_SLOT = 2'h1
	} mrx_state_e;
endpackage

// >>> mrx_exec.sv
// Notes on behaviour
// - copy work to file in one cycle
// - load literal into work, one cycle
// - literal-load don't-care bits must be zero
// - interrupt return pops stack into pc
// - interrupt return sets global irq enable
// - interrupt return: one word, two cycles
// - literal return loads literal into work
// - literal return pops pc, two cycles
// - subroutine return pops pc, two cycles
module mrx_exec (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// instruction from decoder
	input wire logic instr_valid_i,
	input wire logic [13:0] instr_i,
	// return stack top
	input wire logic [12:0] stack_top_i,
	// working register and file write
	output logic [7:0] work_o,
	output logic file_we_o,
	output logic [6:0] file_addr_o,
	output logic [7:0] file_data_o,
	// program flow
	output logic [12:0] pc_o,
	output logic stack_pop_o,
	output logic global_irq_enable_set_o,
	output logic idle_slot_o,
	output logic illegal_o
);
	// state and output registers
	mrx_pkg::mrx_state_e state_q, state_d;
	logic [7:0] work_q, work_d;
	logic [12:0] pc_q, pc_d;
	logic we_q, pop_q, irq_en_q, illegal_q, slot_q;
	logic [6:0] addr_q;
	logic [7:0] fdata_q;

	// both literal formats share one class field, so one function compares it for each, against its own pattern
	function automatic logic class_is(input logic [13:0] word, input logic [3:0] pattern);
		return word[mrx_pkg::CLASS_LSB +: mrx_pkg::CLASS_W] == pattern;
	endfunction

	// fields of the instruction word
	wire logic [7:0] lit_field = instr_i[mrx_pkg::LIT_LSB +: mrx_pkg::DATA_W];
	wire logic [6:0] faddr_field = instr_i[mrx_pkg::FADDR_LSB +: mrx_pkg::FADDR_W];
	wire logic [1:0] dc_field = instr_i[mrx_pkg::DC_LSB +: mrx_pkg::DC_W];
	wire logic [6:0] copy_field = instr_i[mrx_pkg::COPY_LSB +: mrx_pkg::COPY_W];

	// decode; nothing is taken while a return finishes
	wire logic exec = instr_valid_i && state_q == mrx_pkg::MRX_EXEC;
	wire logic is_idle = instr_i == mrx_pkg::OP_IDLE;
	wire logic is_ret = instr_i == mrx_pkg::OP_RETURN;
	wire logic is_ret_irq = instr_i == mrx_pkg::OP_RET_IRQ;
	wire logic is_copy = copy_field == mrx_pkg::OP_COPY_HI;
	wire logic lit_class = class_is(instr_i, mrx_pkg::OP_LOAD_LIT_HI);
	// nonzero don't-care bits are refused rather than guessed at
	wire logic is_load_lit = lit_class && dc_field == mrx_pkg::OP_LOAD_LIT_DC;
	wire logic is_ret_lit = class_is(instr_i, mrx_pkg::OP_RET_LIT_HI);
	wire logic any_ret = is_ret || is_ret_irq || is_ret_lit;
	wire logic known = is_idle || is_copy || is_load_lit || any_ret;
	wire logic writes_work = is_load_lit || is_ret_lit;
	wire logic [12:0] pc_inc = pc_q + mrx_pkg::PC_STEP;

	// next values of the one-cycle pulses
	wire logic we_d = exec && is_copy;
	wire logic pop_d = exec && any_ret;
	wire logic irq_en_d = exec && is_ret_irq;
	wire logic illegal_d = exec && !known;

	always_comb begin
		state_d = mrx_pkg::MRX_EXEC;
		work_d = work_q;
		pc_d = pc_q;
		unique case (state_q)
			mrx_pkg::MRX_EXEC: begin
				if (exec) begin
					pc_d = pc_inc;
					if (writes_work) begin
						work_d = lit_field;
					end
					if (any_ret) begin
						pc_d = stack_top_i;
						state_d = mrx_pkg::MRX_IDLE_SLOT;
					end
				end
			end
			mrx_pkg::MRX_IDLE_SLOT: begin
				// the step stands for the fetch at the restored pc
				pc_d = pc_inc;
			end
			default: begin
				state_d = mrx_pkg::MRX_EXEC;
			end
		endcase
	end

	// slot flag kept as its own flop so the output needs no decode
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_q <= mrx_pkg::MRX_EXEC;
			work_q <= mrx_pkg::W_RESET;
			pc_q <= mrx_pkg::PC_RESET;
			slot_q <= 1'b0;
		end else begin
			state_q <= state_d;
			work_q <= work_d;
			pc_q <= pc_d;
			slot_q <= state_d == mrx_pkg::MRX_IDLE_SLOT;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			we_q <= 1'b0;
			addr_q <= 7'h00;
			fdata_q <= 8'h00;
			pop_q <= 1'b0;
			irq_en_q <= 1'b0;
			illegal_q <= 1'b0;
		end else begin
			we_q <= we_d;
			addr_q <= faddr_field;
			// work as it stood before the move is what gets written
			fdata_q <= work_q;
			pop_q <= pop_d;
			irq_en_q <= irq_en_d;
			illegal_q <= illegal_d;
		end
	end

	assign work_o = work_q;
	assign pc_o = pc_q;
	assign file_we_o = we_q;
	assign file_addr_o = addr_q;
	assign file_data_o = fdata_q;
	assign stack_pop_o = pop_q;
	assign global_irq_enable_set_o = irq_en_q;
	assign idle_slot_o = slot_q;
	assign illegal_o = illegal_q;

	chk_copy_write: assert property (@(posedge mclk_i) disable iff (rst_i)
		exec && is_copy |=> file_we_o && file_addr_o == $past(instr_i[6:0])
			&& file_data_o == $past(work_q)) else $error("file write missing");

	chk_copy_single: assert property (@(posedge mclk_i) disable iff (rst_i)
		exec && is_copy |=> !idle_slot_o && !stack_pop_o && $stable(work_o)
			&& pc_o == $past(pc_o) + 13'h0001) else $error("file copy took extra cycle");

	chk_literal_load: assert property (@(posedge mclk_i) disable iff (rst_i)
		exec && is_load_lit |=> work_o == $past(instr_i[7:0])) else $error("literal not in work");

	chk_literal_single: assert property (@(posedge mclk_i) disable iff (rst_i)
		exec && is_load_lit |=> !idle_slot_o && !file_we_o && pc_o == $past(pc_o) + 13'h0001)
		else $error("literal load took extra cycle");

	chk_dontcare_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
		exec && class_is(instr_i, mrx_pkg::OP_LOAD_LIT_HI) && instr_i[9:8] != 2'h0 |=> illegal_o
			&& work_o == $past(work_q)) else $error("bad don't-care bits accepted");

	chk_irq_ret_pop: assert property (@(posedge mclk_i) disable iff (rst_i)
		exec && is_ret_irq |=> stack_pop_o && pc_o == $past(stack_top_i))
		else $error("interrupt return did not pop");

	chk_pop_single: assert property (@(posedge mclk_i) disable iff (rst_i)
		stack_pop_o |=> !stack_pop_o) else $error("stack popped twice");

	chk_irq_enable_set: assert property (@(posedge mclk_i) disable iff (rst_i)
		global_irq_enable_set_o |-> $past(exec && is_ret_irq)) else $error("stray irq enable");

	chk_enable_with_pop: assert property (@(posedge mclk_i) disable iff (rst_i)
		global_irq_enable_set_o |-> stack_pop_o && idle_slot_o)
		else $error("irq enable without return");

	chk_irq_ret_two: assert property (@(posedge mclk_i) disable iff (rst_i)
		exec && is_ret_irq |=> idle_slot_o ##1 !idle_slot_o) else $error("not two cycles");

	chk_lit_ret_work: assert property (@(posedge mclk_i) disable iff (rst_i)
		exec && is_ret_lit |=> work_o == $past(instr_i[7:0]))
		else $error("literal return work wrong");

	chk_lit_ret_pc: assert property (@(posedge mclk_i) disable iff (rst_i)
		exec && is_ret_lit |=> pc_o == $past(stack_top_i) && idle_slot_o)
		else $error("literal return pc wrong");

	chk_return_pc: assert property (@(posedge mclk_i) disable iff (rst_i)
		exec && is_ret |=> stack_pop_o && pc_o == $past(stack_top_i) ##1 !stack_pop_o)
		else $error("return pc wrong");

	chk_idle_step: assert property (@(posedge mclk_i) disable iff (rst_i)
		exec && is_idle |=> pc_o == $past(pc_q) + 13'h0001 && work_o == $past(work_q)
			&& !file_we_o && !stack_pop_o) else $error("idle changed state");

	chk_slot_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
		idle_slot_o |=> !file_we_o && !stack_pop_o && $stable(work_o))
		else $error("idle slot not idle");

	chk_slot_fetch: assert property (@(posedge mclk_i) disable iff (rst_i)
		idle_slot_o |=> !idle_slot_o && pc_o == $past(pc_o) + 13'h0001)
		else $error("idle slot did not step pc");

	// reset must win even over an instruction taken at the same edge
	chk_reset_clear: assert property (@(posedge mclk_i)
		rst_i |=> pc_o == mrx_pkg::PC_RESET && work_o == mrx_pkg::W_RESET && !idle_slot_o
			&& !file_we_o && !stack_pop_o && !global_irq_enable_set_o && !illegal_o)
		else $error("reset left state behind");
endmodule // mrx_exec

// >>> tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [13:0] w; logic [12:0] st; logic [7:0] wk; logic [3:0] fl;} mrx_row_s;
	logic mclk_i = 0, rst_i = 1, instr_valid_i = 0;
	logic [13:0] instr_i = 14'h0000;
	logic [12:0] stack_top_i = 13'h0000, pc_o, pc_m;
	logic [7:0] work_o, file_data_o, wk_m;
	logic [6:0] file_addr_o;
	logic file_we_o, stack_pop_o, global_irq_enable_set_o, idle_slot_o, illegal_o;
	int bad_count = 0, checks_done = 0, cyc = 0;
	// flags: file write, pop, irq enable set, illegal
	mrx_row_s rows [10] = '{'{14'h305A, 13'h0123, 8'h5A, 4'h0}, '{14'h00FF, 13'h0123, 8'h5A, 4'h8},
		'{14'h0080, 13'h0123, 8'h5A, 4'h8}, '{14'h0000, 13'h0123, 8'h5A, 4'h0},
		'{14'h34FF, 13'h1ABC, 8'hFF, 4'h4}, '{14'h0009, 13'h1FFF, 8'hFF, 4'h6},
		'{14'h0008, 13'h0000, 8'hFF, 4'h4}, '{14'h3200, 13'h0555, 8'hFF, 4'h1},
		'{14'h3000, 13'h0555, 8'h00, 4'h0}, '{14'h0700, 13'h0555, 8'h00, 4'h1}};
	mrx_exec u_dut (.mclk_i, .rst_i, .instr_valid_i, .instr_i, .stack_top_i, .work_o, .file_we_o,
		.file_addr_o, .file_data_o, .pc_o, .stack_pop_o, .global_irq_enable_set_o, .idle_slot_o,
		.illegal_o);
	initial forever #12.5 mclk_i = ~mclk_i;
	task automatic chk(string n, logic [13:0] seen, logic [13:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// released stack lines show the inverse so a late read is caught
	task automatic go(logic [13:0] w, logic [12:0] st);
		@(posedge mclk_i);
		instr_i <= w;
		stack_top_i <= st;
		instr_valid_i <= 1'b1;
		@(posedge mclk_i);
		instr_valid_i <= 1'b0;
		stack_top_i <= ~st;
		#1;
	endtask
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'b0;
		#1;
		pc_m = 13'h0000;
		wk_m = 8'h00;
		chk("rst", {pc_o, idle_slot_o}, 14'h0000);
		chk("rst_out", {work_o, file_we_o, stack_pop_o, global_irq_enable_set_o, illegal_o},
			14'h0000);
		foreach (rows[i]) begin
			go(rows[i].w, rows[i].st);
			pc_m = rows[i].fl[2] ? rows[i].st : pc_m + 13'h0001;
			chk("work", work_o, rows[i].wk);
			chk("pc", pc_o, pc_m);
			chk("flags", {file_we_o, stack_pop_o, global_irq_enable_set_o, illegal_o}, rows[i].fl);
			chk("slot", idle_slot_o, rows[i].fl[2]);
			if (rows[i].fl[3]) begin
				chk("faddr", file_addr_o, rows[i].w[6:0]);
				chk("fdata", file_data_o, wk_m);
			end
			if (rows[i].fl[2]) begin
				@(posedge mclk_i);
				#1;
				pc_m = pc_m + 13'h0001;
				chk("slotpc", {pc_o, idle_slot_o}, {pc_m, 1'b0});
			end
			wk_m = rows[i].wk;
		end
		// a load presented during the idle slot must wait for the following edge
		@(posedge mclk_i);
		instr_i <= 14'h3411;
		stack_top_i <= 13'h0100;
		instr_valid_i <= 1'b1;
		@(posedge mclk_i);
		instr_i <= 14'h3022;
		stack_top_i <= 13'h1EFF;
		@(posedge mclk_i);
		#1;
		chk("ignored", {work_o, pc_o[5:0]}, 14'h0441);
		chk("ignored_flags", {file_we_o, stack_pop_o, illegal_o, idle_slot_o}, 4'h0);
		@(posedge mclk_i);
		instr_valid_i <= 1'b0;
		#1;
		chk("after", {work_o, pc_o[5:0]}, 14'h0882);
		// reset must win over an interrupt return taken at the same edge
		@(posedge mclk_i);
		instr_i <= 14'h0009;
		stack_top_i <= 13'h0ABC;
		instr_valid_i <= 1'b1;
		rst_i <= 1'b1;
		@(posedge mclk_i);
		rst_i <= 1'b0;
		instr_valid_i <= 1'b0;
		#1;
		chk("rst2", {pc_o, idle_slot_o}, 14'h0000);
		chk("rst2_out", {work_o, file_we_o, stack_pop_o, global_irq_enable_set_o, illegal_o},
			14'h0000);
		final_report();
	end
endmodule // tb_top
